// [design/srt_timer.sv]
`include "srt_defs.svh"
`default_nettype none
module srt_timer
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   sys_rst,
    // configuration
    input  wire logic [`SRT_CTL_WIDTH-1:0] timer_control_reg,
    input  wire logic                   timer_on,
    input  wire logic [CNT_W-1:0]       period_value,
    input  wire logic                   flag_clear,
    // clock and gate sources
    input  wire logic                   instruction_cycle_clock,
    input  wire logic                   ext_timer_clock_pin,
    input  wire logic                   xtal_32k_clock,
    input  wire logic                   xtal_32k_select,
    input  wire logic                   gate_in,
    // status
    output var  logic [CNT_W-1:0]       count_value,
    output var  logic                   period_flag,
    output var  srt_pkg::srt_mode_t     mode_state
);
    import srt_pkg::*;

    // the wrap compare and the step constants assume a 16-bit count
    if (CNT_W != 16)
    begin : g_bad_width
        $error("srt_timer supports only a 16-bit counter");
    end

    logic       clock_source_select;
    logic       ext_clock_sync_select;
    logic       gate_enable;
    logic       ext_raw;
    logic       pin_s;
    logic       xtal_s;
    logic       ext_s;
    logic       cyc_s;
    logic       gate_s;
    logic       ext_prev_reg;
    logic       cyc_prev_reg;
    logic       ext_edge;
    logic       cyc_edge;
    logic       async_tick_reg;
    logic       ext_pre_reg;
    logic       tick;
    srt_mode_t  mode_next;

    assign clock_source_select   = timer_control_reg[`SRT_CTL_SRC_BIT];
    assign ext_clock_sync_select = timer_control_reg[`SRT_CTL_SYNC_BIT];
    assign gate_enable           = timer_control_reg[`SRT_CTL_GATE_BIT];

    // both external sources are brought onto clk_sys before the select, so
    // no logic ever looks at a level that may still be settling
    srt_sync2 u_sync_pin
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (ext_timer_clock_pin),
        .dout    (pin_s)
    );

    srt_sync2 u_sync_xtal
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (xtal_32k_clock),
        .dout    (xtal_s)
    );

    // the crystal replaces the pin as external source
    assign ext_raw = xtal_32k_select ? xtal_s : pin_s;

    // mode decode
    always_comb
    begin
        if (!clock_source_select)
            mode_next = gate_enable ? SRT_MODE_GATED : SRT_MODE_TIMER;
        else
            mode_next = ext_clock_sync_select ? SRT_MODE_SYNC_CNT
                                              : SRT_MODE_ASYNC_CNT;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            mode_state <= SRT_MODE_TIMER;
        else
            mode_state <= mode_next;
    end

    // prescaler stage: divide-by-one, a register that copies ext_raw on every clk_sys edge so the
    // sync point follows it rather than the raw pin
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ext_pre_reg <= 1'b0;
        else
            ext_pre_reg <= ext_raw;
    end

    srt_sync2 u_sync_ext
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (ext_pre_reg),
        .dout    (ext_s)
    );

    srt_sync2 u_sync_cyc
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (instruction_cycle_clock),
        .dout    (cyc_s)
    );

    srt_sync2 u_sync_gate
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (gate_in),
        .dout    (gate_s)
    );

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ext_prev_reg <= 1'b0;
            cyc_prev_reg <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= ext_s;
            cyc_prev_reg <= cyc_s;
        end
    end

    assign ext_edge = ext_s & ~ext_prev_reg;
    assign cyc_edge = cyc_s & ~cyc_prev_reg;

    // async mode skips the prescaler and its resync stage: shorter latency,
    // the only settling time spent is the one at the pin or crystal input
    logic raw_prev_reg;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            raw_prev_reg   <= 1'b0;
            async_tick_reg <= 1'b0;
        end
        else
        begin
            raw_prev_reg   <= ext_raw;
            async_tick_reg <= ext_raw & ~raw_prev_reg;
        end
    end

    always_comb
    begin
        unique case (mode_state)
            SRT_MODE_TIMER:     tick = cyc_edge;
            SRT_MODE_GATED:     tick = cyc_edge & gate_s;
            SRT_MODE_SYNC_CNT:  tick = ext_edge;
            SRT_MODE_ASYNC_CNT: tick = async_tick_reg;
        endcase
    end

    // count register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            count_value <= `SRT_CNT_RESET;
        else if (timer_on && tick)
        begin
            if (count_value == period_value)
                count_value <= '0;
            else
                count_value <= count_value + 16'h0001;
        end
    end

    // sticky period flag: a new match wins over a clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            period_flag <= 1'b0;
        else if (timer_on && tick && count_value == period_value)
            period_flag <= 1'b1;
        else if (flag_clear)
            period_flag <= 1'b0;
    end

    sequence s_match_tick;
        timer_on && tick && (count_value == period_value);
    endsequence

    a_period_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_match_tick |=> (count_value == 16'h0000) && period_flag)
        else $error("counter did not wrap at period");

    a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (timer_on && tick && count_value != period_value)
        |=> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not step by one");

    a_count_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!(timer_on && tick)) |=> $stable(count_value))
        else $error("counter moved without a tick");

    a_gate_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_state == SRT_MODE_GATED && !gate_s) |-> !tick)
        else $error("gated mode counted with gate low");

    a_mode_timer: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!timer_control_reg[1] && !timer_control_reg[6]) |=> mode_state == SRT_MODE_TIMER)
        else $error("timer mode decode wrong");

    a_mode_async: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (timer_control_reg[1] && !timer_control_reg[2]) |=> mode_state == SRT_MODE_ASYNC_CNT)
        else $error("async mode decode wrong");

    a_mode_sync: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (timer_control_reg[1] && timer_control_reg[2]) |=> mode_state == SRT_MODE_SYNC_CNT)
        else $error("sync mode decode wrong");

    a_int_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_state == SRT_MODE_TIMER) |-> tick == cyc_edge)
        else $error("timer mode not on cycle clock");

    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (period_flag && !flag_clear) |=> period_flag)
        else $error("period flag dropped without clear");

endmodule : srt_timer
`default_nettype wire

// [design/srt_defs.svh]
`ifndef SRT_DEFS_SVH
`define SRT_DEFS_SVH
// control word bit positions
`define SRT_CTL_SRC_BIT   1
`define SRT_CTL_SYNC_BIT  2
`define SRT_CTL_GATE_BIT  6
`define SRT_CTL_WIDTH     16
`define SRT_CTL_RESET     16'h0000
`define SRT_CNT_RESET     16'h0000
`define SRT_PER_RESET     16'hffff
`endif

// [design/srt_pkg.sv]
`default_nettype none
package srt_pkg;
    typedef enum logic [1:0] {
        SRT_MODE_TIMER,
        SRT_MODE_GATED,
        SRT_MODE_SYNC_CNT,
        SRT_MODE_ASYNC_CNT
    } srt_mode_t;
endpackage : srt_pkg
`default_nettype wire

// [design/srt_sync2.sv]
`default_nettype none
module srt_sync2
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // level in and out
    input  wire logic din,
    output var  logic dout
);
    logic meta_reg;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_reg <= 1'b0;
            dout     <= 1'b0;
        end
        else
        begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule : srt_sync2
`default_nettype wire

// [verification/srt_clk_src.sv]
`default_nettype none
module srt_clk_src
#(
    parameter int HALF = 3
)
(
    // clock
    input  wire logic       clk_sys,
    // burst request
    input  wire logic       start,
    input  wire logic [7:0] edges,
    // source side
    output var  logic       clk_out,
    output var  logic       busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    int left = 0;
    initial clk_out = 1'b0;
    // stands low between bursts so no stray edge reaches the pin
    always @(posedge clk_sys)
    begin
        if (start)
            left <= 2 * edges;
        else if (left > 0 && cnt == HALF - 1)
        begin
            clk_out <= ~clk_out;
            left    <= left - 1;
        end
        cnt <= (cnt == HALF - 1 || left == 0) ? 0 : cnt + 1;
    end
    assign busy = (left != 0) || start;
endmodule : srt_clk_src
`default_nettype wire

// [verification/test_sixteen_bit_rtc_capable_timer.sv]
`default_nettype none
module test_sixteen_bit_rtc_capable_timer;
    timeunit 1ns;
    timeprecision 1ns;
    import srt_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] ctl     = 16'h0000;
    logic [15:0] per     = 16'hffff;
    logic        on      = 1'b1;
    logic        clr     = 1'b0;
    logic        xsel    = 1'b0;
    logic        gate    = 1'b0;
    logic [2:0]  start   = 3'h0;
    logic [7:0]  edges   = 8'h00;
    logic [2:0]  busy;
    logic [2:0]  sclk;
    logic [15:0] count;
    logic        flag;
    srt_mode_t   mode;
    int          errors  = 0;
    int          checks  = 0;
    int          cycles  = 0;

    initial forever #50 clk_sys = ~clk_sys;

    // 0 cycle clock, 1 pin, 2 crystal; half periods of 2, 3 and 4 clk_sys cycles
    for (genvar i = 0; i < 3; i++)
    begin : g_src
        srt_clk_src #(.HALF(i + 2)) u_src (.clk_sys(clk_sys), .start(start[i]),
            .edges(edges), .clk_out(sclk[i]), .busy(busy[i]));
    end

    srt_timer u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .timer_control_reg(ctl),
        .timer_on(on), .period_value(per), .flag_clear(clr),
        .instruction_cycle_clock(sclk[0]), .ext_timer_clock_pin(sclk[1]),
        .xtal_32k_clock(sclk[2]), .xtal_32k_select(xsel), .gate_in(gate),
        .count_value(count), .period_flag(flag), .mode_state(mode));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_rst(input logic [15:0] c);
        sys_rst <= 1'b1;
        ctl     <= c;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : do_rst

    task automatic run(input int s, input int n);
        int k;
        repeat (3) @(posedge clk_sys);
        start    <= 3'h1 << s;
        edges    <= 8'(n);
        @(posedge clk_sys);
        start    <= 3'h0;
        for (k = 0; k < 500 && busy[s] !== 1'b0; k++)
            @(posedge clk_sys);
        // covers the slowest sync path plus the count register
        repeat (8) @(posedge clk_sys);
    endtask : run

    task automatic t_modes();
        logic [15:0] v[4] = '{16'h0004, 16'h0040, 16'h0046, 16'hffba};
        for (int i = 0; i < 4; i++)
        begin
            ctl <= v[i];
            repeat (3) @(posedge clk_sys);
            chk({14'h0, mode}, 16'(i));
        end
    endtask : t_modes

    task automatic t_timer();
        do_rst(16'h0000);
        chk(count, 16'h0000);
        chk({15'h0, flag}, 16'h0000);
        run(1, 4);
        run(0, 5);
        chk(count, 16'h0005);
    endtask : t_timer

    task automatic t_gated();
        do_rst(16'h0040);
        run(0, 4);
        chk(count, 16'h0000);
        gate <= 1'b1;
        run(0, 6);
        chk(count, 16'h0006);
        gate <= 1'b0;
    endtask : t_gated

    task automatic t_counters();
        do_rst(16'h0006);
        run(0, 3);
        run(1, 7);
        chk(count, 16'h0007);
        do_rst(16'h0002);
        xsel <= 1'b1;
        run(1, 2);
        run(2, 9);
        chk(count, 16'h0009);
        xsel <= 1'b0;
    endtask : t_counters

    task automatic t_wrap();
        do_rst(16'h0000);
        per <= 16'h0003;
        run(0, 5);
        chk(count, 16'h0001);
        chk({15'h0, flag}, 16'h0001);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({15'h0, flag}, 16'h0000);
        per <= 16'hffff;
        on  <= 1'b0;
        run(0, 4);
        chk(count, 16'h0001);
        on  <= 1'b1;
    endtask : t_wrap

    task automatic test_done();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        do_rst(16'h0000);
        chk({14'h0, mode}, {14'h0, SRT_MODE_TIMER});
        t_modes();
        t_timer();
        t_gated();
        t_counters();
        t_wrap();
        test_done();
    end
endmodule : test_sixteen_bit_rtc_capable_timer
`default_nettype wire
